// ### design/emg_pkg.sv
// Shared constants for the emulator glue decoder.
// Assumes a 13-bit processor address bus, 8-bit data, one system clock.
package emg_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    // Program store windows
    localparam logic [12:0] STORE0_LO = 13'h0080;
    localparam logic [12:0] STORE0_HI = 13'h07ff;
    localparam logic [12:0] STORE1_LO = 13'h0800;
    localparam logic [12:0] STORE1_HI = 13'h0fff;
    localparam logic [12:0] STORE1_USE_HI = 13'h08af;
    localparam logic [12:0] STORE2_LO = 13'h1800;
    localparam logic [12:0] STORE2_HI = 13'h1fff;
    localparam logic [12:0] SELFCHK_LO = 13'h1f80;
    localparam logic [12:0] SELFCHK_HI = 13'h1ff5;
    localparam logic [12:0] VECTOR_LO = 13'h1ff6;
    // Small target: 2 K byte space
    localparam logic [12:0] SMALL_MASK = 13'h07ff;
    localparam logic [12:0] SMALL_BASE = 13'h1800;
    // Extra port register slots (C data, D data, C dir, D dir)
    localparam logic [12:0] PORTC_DATA = 13'h0002;
    localparam logic [12:0] PORTD_DATA = 13'h0003;
    localparam logic [12:0] PORTC_DIR = 13'h0006;
    localparam logic [12:0] PORTD_DIR = 13'h0007;
    // Input-only line register slot
    localparam logic [12:0] INPUT_REG = 13'h0003;
    localparam logic [3:0] INPUT_PAD = 4'hf;
    // Oscillator ratio in quarters: x1.25 = 5/4, x2.5 = 10/4
    localparam logic [3:0] OSC_MUL_DIV4 = 4'h5;
    localparam logic [3:0] OSC_MUL_DIV2 = 4'ha;
    // Expander register selects
    localparam logic [1:0] SEL_CDATA = 2'h0;
    localparam logic [1:0] SEL_DDATA = 2'h1;
    localparam logic [1:0] SEL_CDIR = 2'h2;
    localparam logic [1:0] SEL_DDIR = 2'h3;
endpackage

// ### design/emg_edge_irq.sv
// Edge-only interrupt adapter.
// Assumes the interrupt line and acknowledge are synchronous to clk_sys.
module emg_edge_irq
    import emg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic edgeOnly,
    input wire logic irqIn_n,
    input wire logic irqAck,
    output logic irqOut_n
);
    logic prevIrq_r, prevIrq_nxt;
    logic pend_r, pend_nxt;
    logic fall;

    // Next state: falling edge sets, acknowledge clears, set wins
    always_comb begin
        prevIrq_nxt = irqIn_n;
        fall = prevIrq_r & ~irqIn_n;
        pend_nxt = pend_r;
        if (irqAck) begin
            pend_nxt = 1'b0;
        end
        if (fall) begin
            pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prevIrq_r <= 1'b1;
            pend_r <= 1'b0;
        end else if (clkEn) begin
            prevIrq_r <= prevIrq_nxt;
            pend_r <= pend_nxt;
        end
    end

    // held level ignored in edge mode
    assign irqOut_n = edgeOnly ? ~pend_r : irqIn_n;

    AST_EDGE_SETS: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && prevIrq_r && !irqIn_n) |=> pend_r)
        else $error("falling edge not latched");
    AST_ACK_CLEARS: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && irqAck && !(prevIrq_r && !irqIn_n)) |=> !pend_r)
        else $error("acknowledge did not clear request");
    AST_LEVEL_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && edgeOnly && irqAck && !prevIrq_r && !irqIn_n) |=> (!edgeOnly || irqOut_n))
        else $error("held level raised an interrupt");
endmodule

// ### design/emg_glue.sv
// What this block does
// - Store 0 decodes 0x0080 to 0x07FF only
// - Store 1 decodes 0x0800 to 0x0FFF
// - Store 2 decodes 0x1800 to 0x1FFF
// - Substitute memory sits at ROM addresses
// - Expander registers map into spare slots
// - Expander supplies ports C and D
// - Oscillator runs 1.25 or 2.5 times target
// - Edge-only mode ignores held interrupt level
// - Small target folds into 2 K space
// - Input lines buffered, enabled on read only
// - Input register bits 4-7 read one
//
// Emulator glue: address decode, input buffer, interrupt and clock-ratio logic.
// Assumes the processor's demultiplexed address, read strobe and valid strobe
// are synchronous to clk_sys; the far side drives memories and the expander.
module emg_glue
    import emg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [12:0] busAddr,
    input wire logic busValid,
    input wire logic busRead,
    input wire logic smallTarget,
    input wire logic edgeOnly,
    input wire logic divByTwo,
    input wire logic [3:0] inLines,
    input wire logic irqIn_n,
    input wire logic irqAck,
    output logic store0Sel,
    output logic store1Sel,
    output logic store2Sel,
    output logic [10:0] storeAddr,
    output logic store1Usable,
    output logic selfCheckHit,
    output logic vectorHit,
    output logic expSel,
    output logic [1:0] expReg,
    output logic inBufOe,
    output logic [7:0] inBufData,
    output logic [3:0] oscMulQuarters,
    output logic irqOut_n
);
    logic [12:0] effAddr;
    logic s0, s1, s2, xs, ib;
    logic [1:0] xr;
    logic s0_r, s0_nxt, s1_r, s1_nxt, s2_r, s2_nxt, xs_r, xs_nxt;
    logic ib_r, ib_nxt, use_r, use_nxt, sc_r, sc_nxt, vec_r, vec_nxt;
    logic [1:0] xr_r, xr_nxt;
    logic [10:0] sa_r, sa_nxt;
    logic [7:0] ibd_r, ibd_nxt;
    logic [3:0] osc_r, osc_nxt;

    // Inclusive range test, used by every window
    function automatic logic inRange(input logic [12:0] a, input logic [12:0] lo,
                                     input logic [12:0] hi);
        inRange = (a >= lo) && (a <= hi);
    endfunction

    // fold into 2 K so vectors land at the top
    assign effAddr = smallTarget ? (SMALL_BASE | (busAddr & SMALL_MASK)) : busAddr;

    // Decode; the fold means the small target only ever hits store 2
    always_comb begin
        // first store excludes low RAM and I/O
        s0 = busValid && inRange(effAddr, STORE0_LO, STORE0_HI);
        s1 = busValid && inRange(effAddr, STORE1_LO, STORE1_HI);
        // third store with vectors at top
        s2 = busValid && inRange(effAddr, STORE2_LO, STORE2_HI);
        // expander in the spare port slots
        xs = 1'b0;
        xr = SEL_CDATA;
        ib = 1'b0;
        if (busValid && !smallTarget) begin
            case (busAddr)
                PORTC_DATA: begin
                    xs = 1'b1;
                    xr = SEL_CDATA;
                end
                PORTD_DATA: begin
                    xs = 1'b1;
                    xr = SEL_DDATA;
                end
                PORTC_DIR: begin
                    xs = 1'b1;
                    xr = SEL_CDIR;
                end
                PORTD_DIR: begin
                    xs = 1'b1;
                    xr = SEL_DDIR;
                end
                default: begin
                    xs = 1'b0;
                end
            endcase
        end
        // buffer opens only on a read of its slot
        if (busValid && smallTarget && busRead && busAddr == INPUT_REG) begin
            ib = 1'b1;
        end
    end

    // Next values of registered decode outputs
    always_comb begin
        s0_nxt = s0;
        s1_nxt = s1;
        s2_nxt = s2;
        xs_nxt = xs;
        xr_nxt = xr;
        ib_nxt = ib;
        // store sees the ROM address itself
        sa_nxt = effAddr[10:0];
        // Flag only; loaded code must stay inside
        use_nxt = s1 && inRange(effAddr, STORE1_LO, STORE1_USE_HI);
        sc_nxt = s2 && inRange(effAddr, SELFCHK_LO, SELFCHK_HI);
        vec_nxt = s2 && inRange(effAddr, VECTOR_LO, STORE2_HI);
        // upper bits read as one, lines registered on every enabled cycle
        ibd_nxt = {INPUT_PAD, inLines};
        // oscillator ratio for the target's divider
        osc_nxt = divByTwo ? OSC_MUL_DIV2 : OSC_MUL_DIV4;
    end

    // Register stage; a registered select costs one cycle of decode latency
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s0_r <= 1'b0;
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            xs_r <= 1'b0;
            xr_r <= SEL_CDATA;
            ib_r <= 1'b0;
            sa_r <= 11'h000;
            use_r <= 1'b0;
            sc_r <= 1'b0;
            vec_r <= 1'b0;
            ibd_r <= 8'hff;
            osc_r <= OSC_MUL_DIV4;
        end else if (clkEn) begin
            s0_r <= s0_nxt;
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            xs_r <= xs_nxt;
            xr_r <= xr_nxt;
            ib_r <= ib_nxt;
            sa_r <= sa_nxt;
            use_r <= use_nxt;
            sc_r <= sc_nxt;
            vec_r <= vec_nxt;
            ibd_r <= ibd_nxt;
            osc_r <= osc_nxt;
        end
    end

    assign store0Sel = s0_r;
    assign store1Sel = s1_r;
    assign store2Sel = s2_r;
    assign storeAddr = sa_r;
    assign store1Usable = use_r;
    assign selfCheckHit = sc_r;
    assign vectorHit = vec_r;
    // expander carries ports C and D
    assign expSel = xs_r;
    assign expReg = xr_r;
    assign inBufOe = ib_r;
    assign inBufData = ibd_r;
    assign oscMulQuarters = osc_r;

    // Interrupt adapter
    emg_edge_irq uIrq (
        .clk_sys(clk_sys),
        .rst(rst),
        .clkEn(clkEn),
        .edgeOnly(edgeOnly),
        .irqIn_n(irqIn_n),
        .irqAck(irqAck),
        .irqOut_n(irqOut_n)
    );

    AST_STORE0_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && !smallTarget && busAddr < STORE0_LO) |=> !store0Sel)
        else $error("store 0 selected in low RAM area");
    AST_STORE0_HIT: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && !smallTarget && busAddr == STORE0_LO) |=> store0Sel)
        else $error("store 0 missed its first address");
    AST_STORE1_HIT: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && !smallTarget && busAddr[12:11] == 2'h1) |=> store1Sel)
        else $error("store 1 missed");
    AST_STORE2_HIT: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && busAddr[12:11] == 2'h3) |=> store2Sel && !store0Sel)
        else $error("store 2 missed");
    AST_ONE_STORE: assert property (@(posedge clk_sys) disable iff (rst)
        $onehot0({store0Sel, store1Sel, store2Sel}))
        else $error("two stores selected together");
    AST_VECTOR_FOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && smallTarget && busAddr[10:0] == 11'h7fe) |=> vectorHit)
        else $error("vector not folded to top");
    AST_EXP_SLOT: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && !smallTarget && busAddr == PORTD_DIR)
        |=> expSel && expReg == SEL_DDIR)
        else $error("expander direction slot not decoded");
    AST_INBUF_READ: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && !busRead) |=> !inBufOe)
        else $error("input buffer enabled without read");
    AST_INBUF_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn |=> inBufData == {4'hf, $past(inLines)})
        else $error("input data not ones over the sampled lines");
    AST_OSC_RATIO: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && divByTwo) |=> oscMulQuarters == 4'ha)
        else $error("wrong oscillator ratio");
    AST_GAP_EMPTY: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && !smallTarget && busAddr[12:11] == 2'h2)
        |=> !store0Sel && !store1Sel && !store2Sel)
        else $error("store selected in unmapped gap");
    AST_SMALL_FOLD: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && busValid && smallTarget) |=> store2Sel && !expSel)
        else $error("small target access not folded into store 2");
    AST_IDLE_QUIET: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && !busValid) |=> !inBufOe && !expSel && !store2Sel)
        else $error("select raised without a valid address");
endmodule

// ### sim/emg_far_model.sv
// Far-side model: the target's input-only lines and its interrupt source.
// Assumes one clock; the interrupt line is open drain with a pull-up.
module emg_far_model (
    input wire logic clk_sys,
    input wire logic pullLow,
    output logic [3:0] inLines,
    output logic irqIn_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines never latched
    // New value every cycle, so a stale buffer read shows up
    always @(posedge clk_sys) begin
        inLines <= 4'($urandom);
    end
    // Pull-up holds the line high when nobody sinks it
    assign irqIn_n = pullLow ? 1'b0 : 1'b1;
    initial inLines = 4'h0;
endmodule

// ### sim/emg_glue_tb_top.sv
// Self-checking bench: random decode traffic against an integer model.
// Assumes the far-side model drives the input lines and interrupt line.
module emg_glue_tb_top
    import emg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst = 1, clkEn = 0, busValid = 0, busRead = 0;
    logic smallTarget = 0, edgeOnly = 0, divByTwo = 0, irqAck = 0, pullLow = 0;
    logic [12:0] busAddr = 13'h0000;
    logic [3:0] inLines, eLines;
    logic irqIn_n, store0Sel, store1Sel, store2Sel, store1Usable, selfCheckHit;
    logic vectorHit, expSel, inBufOe, irqOut_n;
    logic [10:0] storeAddr;
    logic [1:0] expReg;
    logic [7:0] inBufData;
    logic [3:0] oscMulQuarters;
    int err_total = 0;
    int checked = 0;
    int eVal, eSmall, eEff, eRd, eRaw, eDiv, pendM, prevM;
    int edges[20] = '{'h0, 'h7f, 'h80, 'h7ff, 'h800, 'h8af, 'h8b0, 'hfff, 'h1000,
        'h17ff, 'h1800, 'h1f7f, 'h1f80, 'h1ff5, 'h1ff6, 'h3, 'h2, 'h6, 'h7, 'h7fe};

    emg_far_model far (.clk_sys(clk_sys), .pullLow(pullLow), .inLines(inLines),
        .irqIn_n(irqIn_n));
    emg_glue dut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .busAddr(busAddr),
        .busValid(busValid), .busRead(busRead), .smallTarget(smallTarget),
        .edgeOnly(edgeOnly), .divByTwo(divByTwo), .inLines(inLines),
        .irqIn_n(irqIn_n), .irqAck(irqAck), .store0Sel(store0Sel),
        .store1Sel(store1Sel), .store2Sel(store2Sel), .storeAddr(storeAddr),
        .store1Usable(store1Usable), .selfCheckHit(selfCheckHit),
        .vectorHit(vectorHit), .expSel(expSel), .expReg(expReg), .inBufOe(inBufOe),
        .inBufData(inBufData), .oscMulQuarters(oscMulQuarters), .irqOut_n(irqOut_n));

    // Free-running system clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input int ex, input logic [12:0] got);
        checked++;
        if (got !== 13'(ex)) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
        end
    endtask

    // Reset held 8 cycles; outputs checked while it is held
    task automatic do_reset(input logic mode);
        @(posedge clk_sys);
        rst <= 1'b1;
        clkEn <= 1'b0;
        pullLow <= 1'b0;
        edgeOnly <= mode;
        repeat (8) @(posedge clk_sys);
        chk("rstSel", 0, 13'({store0Sel, store1Sel, store2Sel, expSel, inBufOe}));
        chk("rstData", 'hff, 13'(inBufData));
        chk("rstOsc", 5, 13'(oscMulQuarters));
        chk("rstIrq", 1, 13'(irqOut_n));
        rst <= 1'b0;
        eVal = 0;
        eDiv = 0;
        pendM = 0;
        prevM = 1;
    endtask

    // One cycle: fold in what this edge sampled, drive anew, then compare
    task automatic step();
        int pick;
        @(posedge clk_sys);
        if (clkEn) begin
            eVal = busValid;
            eSmall = smallTarget;
            eRd = busRead;
            eRaw = busAddr;
            eDiv = divByTwo;
            eLines = inLines;
            eEff = eSmall ? ('h1800 | (eRaw & 'h7ff)) : eRaw;
            pendM = (prevM && !irqIn_n) ? 1 : (irqAck ? 0 : pendM);
            prevM = irqIn_n;
        end
        pick = $urandom_range(0, 23);
        clkEn <= ($urandom_range(0, 7) != 0);
        busAddr <= (pick < 20) ? 13'(edges[pick]) : 13'($urandom);
        busValid <= ($urandom_range(0, 5) != 0);
        busRead <= 1'($urandom);
        smallTarget <= 1'($urandom);
        divByTwo <= 1'($urandom);
        irqAck <= !irqAck && ($urandom_range(0, 3) == 0);
        if ($urandom_range(0, 3) == 0)
            pullLow <= !pullLow;
        #1;
        chk("store0Sel", eVal && eEff >= 'h80 && eEff <= 'h7ff, 13'(store0Sel));
        chk("store1Sel", eVal && eEff >= 'h800 && eEff <= 'hfff, 13'(store1Sel));
        chk("store2Sel", eVal && eEff >= 'h1800, 13'(store2Sel));
        if (eVal) begin
            chk("usable", eEff >= 'h800 && eEff <= 'h8af, 13'(store1Usable));
            chk("selfChk", eEff >= 'h1f80 && eEff <= 'h1ff5, 13'(selfCheckHit));
            chk("vector", eEff >= 'h1ff6, 13'(vectorHit));
        end
        if (eVal && (store0Sel || store1Sel || store2Sel))
            chk("storeAddr", eEff & 'h7ff, 13'(storeAddr));
        chk("expSel", eVal && !eSmall && (eRaw & 'h1ffc) inside {'h0, 'h4} && eRaw[1],
            13'(expSel));
        if (expSel === 1'b1)
            chk("expReg", ((eRaw >> 1) & 2) | (eRaw & 1), 13'(expReg));
        chk("inBufOe", eVal && eRd && eSmall && eRaw == 3, 13'(inBufOe));
        if (inBufOe === 1'b1)
            chk("inBufData", 'hf0 | eLines, 13'(inBufData));
        chk("oscMul", eDiv ? 10 : 5, 13'(oscMulQuarters));
        chk("irqOut_n", edgeOnly ? !pendM : irqIn_n, 13'(irqOut_n));
    endtask

    task automatic end_of_test();
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Level mode first, then a mid-run reset into edge-only mode
    initial begin
        void'($urandom(32'h651a));
        do_reset(1'b0);
        repeat (800) step();
        do_reset(1'b1);
        repeat (800) step();
        end_of_test();
    end
endmodule
